// ===== common/dmms_pkg.sv
// Package: constants and carrier types for the memory map and select block
package dmms_pkg;

  // Timing: input clock at five times the processor cycle rate
  localparam int unsigned CYCLE_NS          = 25;
  localparam int unsigned MCLK_NS           = 5;
  localparam int unsigned CYCLE_CLKS        = (CYCLE_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned HALF_CYCLE_CLKS   = (CYCLE_CLKS / 2 > 0) ? CYCLE_CLKS / 2 : 1;

  // Address widths
  localparam int unsigned ADDR_W            = 14;
  localparam int unsigned OVL_LOW_W         = 13;
  localparam int unsigned IO_ADDR_W         = 11;
  localparam int unsigned IO_REGION_LSB     = 9;
  localparam int unsigned WAIT_W            = 3;
  localparam int unsigned OVL_W             = 2;

  // Program space
  localparam logic [13:0] PM_OVL_FIRST      = 14'h2000;
  localparam logic [13:0] PM_OVL_LAST       = 14'h3FFF;
  // Data space
  localparam logic [13:0] DM_OVL_FIRST      = 14'h0000;
  localparam logic [13:0] DM_OVL_LAST       = 14'h1FFF;
  localparam logic [13:0] DM_INT_FIRST      = 14'h2000;
  localparam logic [13:0] DM_INT_LAST       = 14'h2FFF;
  localparam logic [13:0] DM_RSV_FIRST      = 14'h3000;
  localparam logic [13:0] DM_RSV_LAST       = 14'h3FDF;
  localparam logic [13:0] DM_MMR_FIRST      = 14'h3FE0;
  localparam logic [13:0] DM_MMR_LAST       = 14'h3FFF;
  // First instruction address after boot
  localparam logic [13:0] BOOT_START_ADDR   = 14'h0000;
  localparam int unsigned BOOT_WORDS        = 32;

  // Overlay select codes
  localparam logic [1:0]  OVL_INTERNAL      = 2'h0;
  localparam logic [1:0]  OVL_ONE           = 2'h1;
  localparam logic [1:0]  OVL_TWO           = 2'h2;

  // Composite select enable bit positions and reset value
  localparam int unsigned CMS_PM_BIT        = 0;
  localparam int unsigned CMS_DM_BIT        = 1;
  localparam int unsigned CMS_BM_BIT        = 2;
  localparam int unsigned CMS_IO_BIT        = 3;
  localparam logic [3:0]  CMS_EN_RESET      = 4'hB;
  localparam logic [15:0] MODE_STATUS_REG_RESET       = 16'h0000;
  localparam logic [WAIT_W-1:0] WAIT_RESET  = 3'h7;

  typedef enum logic [1:0] {
    DMMS_SP_PROG,
    DMMS_SP_DATA,
    DMMS_SP_BYTE,
    DMMS_SP_IO
  } dmms_space_t;

  // Core access request
  typedef struct packed {
    logic        valid;
    logic        write;
    dmms_space_t space;
    logic [13:0] addr;
  } dmms_req_t;

  // External select strobes, active high inside, inverted at pins
  typedef struct packed {
    logic prog;
    logic data;
    logic byte_sel;
    logic io;
  } dmms_sel_t;

endpackage : dmms_pkg

// ===== hdl/dmms_map.sv
// Memory map decode, overlay addressing, wait states and memory selects
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dmms_map
  import dmms_pkg::*;
#(
  parameter int unsigned PM_WORDS = 4096,
  parameter int unsigned DM_WORDS = 4096,
  parameter int unsigned STACK_W  = 4
) (
  input  wire logic              MCLK_I,
  input  wire logic              RST_I,
  // Configuration pins
  input  wire logic              MODE_B_I,
  input  wire logic              BOOT_EN_I,
  input  wire logic              BUS_REQ_I,
  input  wire logic              BOOT_DONE_I,
  // Register port
  input  wire logic [7:0]        REG_ADDR_I,
  input  wire logic [15:0]       REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [15:0]       REG_RDATA_O,
  // Core access port
  input  wire dmms_req_t         DATA_REQ_I,
  input  wire logic              IFETCH_I,
  input  wire logic [13:0]       IFETCH_ADDR_I,
  input  wire logic [23:0]       PM_WDATA_I,
  output logic      [23:0]       IFETCH_DATA_O,
  output logic      [23:0]       PM_RDATA_O,
  output logic      [15:0]       DM_RDATA_O,
  output logic                   STALL_O,
  output logic                   INT_ACCESS_O,
  output logic                   MMR_ACCESS_O,
  output logic                   BAD_ACCESS_O,
  output logic      [13:0]       FETCH_START_O,
  output logic                   CORE_RUN_O,
  // External memory pins
  output logic      [13:0]       EXT_ADDR_O,
  output logic                   EXT_RD_O,
  output logic                   EXT_WR_O,
  output logic                   PMS_N_O,
  output logic                   DMS_N_O,
  output logic                   BMS_N_O,
  output logic                   IO_SPACE_SELECT_N_O,
  output logic                   CMS_N_O,
  output logic                   BUS_GRANT_O,
  output logic                   CYCLE_CLOCK_O,
  output logic      [15:0]       MODE_STATUS_O,
  output logic      [15:0]       IRQ_MASK_O,
  output logic      [STACK_W-1:0] STACK_PTR_O
);

  // Register indices on the register port
  localparam logic [7:0] RA_PM_OVL  = 8'h00;
  localparam logic [7:0] RA_DM_OVL  = 8'h01;
  localparam logic [7:0] RA_DATA_WAIT_COUNT   = 8'h02;
  localparam logic [7:0] RA_IOWAIT  = 8'h03;
  localparam logic [7:0] RA_CMS_EN  = 8'h04;
  localparam logic [7:0] RA_CLK_DIS = 8'h05;
  localparam logic [7:0] RA_MODE_STATUS_REG   = 8'h06;
  localparam logic [7:0] RA_IMASK   = 8'h07;
  localparam logic [7:0] RA_STATUS  = 8'h08;

  typedef enum logic [1:0] {
    DMMS_IDLE,
    DMMS_WAIT,
    DMMS_DONE
  } dmms_state_t;

  // Pin input synchronisers
  logic [1:0] mode_b_sync_ff;
  logic [1:0] boot_en_sync_ff;
  logic [1:0] bus_req_sync_ff;
  logic [1:0] boot_done_sync_ff;
  logic       mode_b;
  logic       bus_req;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      mode_b_sync_ff    <= 2'h0;
      boot_en_sync_ff   <= 2'h0;
      bus_req_sync_ff   <= 2'h0;
      boot_done_sync_ff <= 2'h0;
    end else begin
      mode_b_sync_ff    <= {mode_b_sync_ff[0], MODE_B_I};
      boot_en_sync_ff   <= {boot_en_sync_ff[0], BOOT_EN_I};
      bus_req_sync_ff   <= {bus_req_sync_ff[0], BUS_REQ_I};
      boot_done_sync_ff <= {boot_done_sync_ff[0], BOOT_DONE_I};
    end
  end

  assign mode_b  = mode_b_sync_ff[1];
  assign bus_req = bus_req_sync_ff[1];

  // Control registers, all software-visible except the stack pointer
  logic [OVL_W-1:0]    pm_ovl_ff;
  logic [OVL_W-1:0]    dm_ovl_ff;
  logic [WAIT_W-1:0]   data_wait_count_ff;
  logic [4*WAIT_W-1:0] iowait_ff;
  logic [3:0]          cms_en_ff;
  logic                clk_dis_ff;
  logic [15:0]         mode_status_reg_ff;
  logic [15:0]         imask_ff;
  logic [STACK_W-1:0]  stack_ptr_ff;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      pm_ovl_ff    <= OVL_INTERNAL;
      dm_ovl_ff    <= OVL_INTERNAL;
      data_wait_count_ff     <= WAIT_RESET;
      iowait_ff    <= {4{WAIT_RESET}};
      cms_en_ff    <= CMS_EN_RESET;
      clk_dis_ff   <= 1'b0;
      mode_status_reg_ff     <= MODE_STATUS_REG_RESET;
      imask_ff     <= 16'h0000;
      stack_ptr_ff <= '0;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        RA_PM_OVL:  pm_ovl_ff  <= REG_WDATA_I[OVL_W-1:0];
        RA_DM_OVL:  dm_ovl_ff  <= REG_WDATA_I[OVL_W-1:0];
        RA_DATA_WAIT_COUNT:   data_wait_count_ff   <= REG_WDATA_I[WAIT_W-1:0];
        RA_IOWAIT:  iowait_ff  <= REG_WDATA_I[4*WAIT_W-1:0];
        RA_CMS_EN:  cms_en_ff  <= REG_WDATA_I[3:0];
        RA_CLK_DIS: clk_dis_ff <= REG_WDATA_I[0];
        RA_MODE_STATUS_REG:   mode_status_reg_ff   <= REG_WDATA_I;
        RA_IMASK:   imask_ff   <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  // Read port: data one cycle after the strobe
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        busy;
  logic        run_ff;

  always_comb begin
    nxt_rdata = 16'h0000;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        RA_PM_OVL:  nxt_rdata = {14'h0000, pm_ovl_ff};
        RA_DM_OVL:  nxt_rdata = {14'h0000, dm_ovl_ff};
        RA_DATA_WAIT_COUNT:   nxt_rdata = {13'h0000, data_wait_count_ff};
        RA_IOWAIT:  nxt_rdata = {4'h0, iowait_ff};
        RA_CMS_EN:  nxt_rdata = {12'h000, cms_en_ff};
        RA_CLK_DIS: nxt_rdata = {15'h0000, clk_dis_ff};
        RA_MODE_STATUS_REG:   nxt_rdata = mode_status_reg_ff;
        RA_IMASK:   nxt_rdata = imask_ff;
        RA_STATUS:  nxt_rdata = {12'h000, mode_b, bus_req, busy, run_ff};
        default:    nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Cycle clock: divider of MCLK, gated by the disable bit
  localparam int unsigned DIV_W = $clog2(HALF_CYCLE_CLKS + 1);
  logic [DIV_W-1:0] div_ff;
  logic             cyc_clk_ff;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      div_ff     <= '0;
      cyc_clk_ff <= 1'b0;
    end else if (div_ff == DIV_W'(HALF_CYCLE_CLKS - 1)) begin
      div_ff     <= '0;
      cyc_clk_ff <= ~cyc_clk_ff;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  // Boot sequencing and first fetch address
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      run_ff <= 1'b0;
    end else if (!run_ff && !bus_req) begin
      if (mode_b || !boot_en_sync_ff[1] || boot_done_sync_ff[1]) begin
        run_ff <= 1'b1;
      end
    end
  end

  // Address decode helpers
  function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo,
                                    input logic [13:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic ovl_top(input logic [OVL_W-1:0] ovl);
    ovl_top = (ovl == OVL_TWO);
  endfunction : ovl_top

  function automatic logic ovl_ext(input logic [OVL_W-1:0] ovl);
    ovl_ext = (ovl == OVL_ONE) || (ovl == OVL_TWO);
  endfunction : ovl_ext

  // Access decode
  logic        pm_ext;
  logic        dm_ext;
  logic        io_acc;
  logic        byte_acc;
  logic        int_acc;
  logic        mmr_acc;
  logic        bad_acc;
  logic [13:0] ext_addr;
  logic [WAIT_W-1:0] wait_cnt;
  logic [1:0]  io_region;
  dmms_req_t   req;

  assign req       = DATA_REQ_I;
  assign io_region = req.addr[IO_REGION_LSB +: 2];

  always_comb begin
    pm_ext   = 1'b0;
    dm_ext   = 1'b0;
    io_acc   = 1'b0;
    byte_acc = 1'b0;
    int_acc  = 1'b0;
    mmr_acc  = 1'b0;
    bad_acc  = 1'b0;
    ext_addr = 14'h0000;
    wait_cnt = '0;
    if (req.valid) begin
      case (req.space)
        DMMS_SP_PROG: begin
          if (mode_b) begin
            pm_ext   = 1'b1;
            ext_addr = req.addr;
          end else if (in_range(req.addr, PM_OVL_FIRST, PM_OVL_LAST)) begin
            if (ovl_ext(pm_ovl_ff)) begin
              pm_ext   = 1'b1;
              ext_addr = {ovl_top(pm_ovl_ff), req.addr[OVL_LOW_W-1:0]};
            end else begin
              bad_acc = 1'b1;
            end
          end else begin
            int_acc = 1'b1;
          end
        end
        DMMS_SP_DATA: begin
          if (in_range(req.addr, DM_OVL_FIRST, DM_OVL_LAST)) begin
            if (ovl_ext(dm_ovl_ff)) begin
              dm_ext   = 1'b1;
              ext_addr = {ovl_top(dm_ovl_ff), req.addr[OVL_LOW_W-1:0]};
              wait_cnt = data_wait_count_ff;
            end else begin
              bad_acc = 1'b1;
            end
          end else if (in_range(req.addr, DM_INT_FIRST, DM_INT_LAST)) begin
            int_acc = 1'b1;
          end else if (in_range(req.addr, DM_MMR_FIRST, DM_MMR_LAST)) begin
            mmr_acc = 1'b1;
          end else begin
            bad_acc = 1'b1;
          end
        end
        DMMS_SP_IO: begin
          io_acc   = 1'b1;
          ext_addr = {3'h0, req.addr[IO_ADDR_W-1:0]};
          wait_cnt = iowait_ff[io_region*WAIT_W +: WAIT_W];
        end
        DMMS_SP_BYTE: begin
          byte_acc = 1'b1;
          ext_addr = req.addr;
        end
        default: ;
      endcase
    end
  end

  // External access sequencer with wait states
  dmms_state_t       state_ff;
  dmms_state_t       nxt_state;
  logic [WAIT_W-1:0] wcnt_ff;
  logic              ext_start;
  dmms_sel_t         sel_ff;
  logic [13:0]       ext_addr_ff;
  logic              ext_wr_ff;

  assign ext_start = (pm_ext || dm_ext || io_acc || byte_acc) && run_ff && !bus_req;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DMMS_IDLE: if (ext_start) nxt_state = (wait_cnt == '0) ? DMMS_DONE : DMMS_WAIT;
      DMMS_WAIT: if (wcnt_ff == WAIT_W'(1)) nxt_state = DMMS_DONE;
      DMMS_DONE: nxt_state = DMMS_IDLE;
      default:   nxt_state = DMMS_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_ff <= DMMS_IDLE;
      wcnt_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == DMMS_IDLE && ext_start) begin
        wcnt_ff <= wait_cnt;
      end else if (state_ff == DMMS_WAIT) begin
        wcnt_ff <= wcnt_ff - WAIT_W'(1);
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      sel_ff      <= '0;
      ext_addr_ff <= 14'h0000;
      ext_wr_ff   <= 1'b0;
    end else if (bus_req) begin
      sel_ff <= '0;
    end else if (state_ff == DMMS_IDLE && ext_start) begin
      sel_ff.prog     <= pm_ext;
      sel_ff.data     <= dm_ext;
      sel_ff.io       <= io_acc;
      sel_ff.byte_sel <= byte_acc;
      ext_addr_ff     <= ext_addr;
      ext_wr_ff       <= req.write;
    end else if (state_ff == DMMS_DONE) begin
      sel_ff <= '0;
    end
  end

  // Composite select from enabled individual selects
  logic composite_select;
  assign composite_select = (sel_ff.prog     && cms_en_ff[CMS_PM_BIT]) ||
               (sel_ff.data     && cms_en_ff[CMS_DM_BIT]) ||
               (sel_ff.byte_sel && cms_en_ff[CMS_BM_BIT]) ||
               (sel_ff.io       && cms_en_ff[CMS_IO_BIT]);

  // On-chip memories: program RAM with two read ports
  logic [23:0] pm_ram [PM_WORDS];
  logic [15:0] dm_ram [DM_WORDS];
  logic [23:0] ifetch_ff;
  logic [23:0] pm_rd_ff;
  logic [15:0] dm_rd_ff;
  localparam int unsigned PMA_W = $clog2(PM_WORDS);
  localparam int unsigned DMA_W = $clog2(DM_WORDS);

  always_ff @(posedge MCLK_I) begin
    if (int_acc && req.write && req.space == DMMS_SP_PROG) begin
      pm_ram[req.addr[PMA_W-1:0]] <= PM_WDATA_I;
    end
    if (int_acc && req.write && req.space == DMMS_SP_DATA) begin
      dm_ram[req.addr[DMA_W-1:0]] <= PM_WDATA_I[15:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ifetch_ff <= 24'h000000;
      pm_rd_ff  <= 24'h000000;
      dm_rd_ff  <= 16'h0000;
    end else begin
      if (IFETCH_I && !mode_b) begin
        ifetch_ff <= pm_ram[IFETCH_ADDR_I[PMA_W-1:0]];
      end
      if (int_acc && req.space == DMMS_SP_PROG) begin
        pm_rd_ff <= pm_ram[req.addr[PMA_W-1:0]];
      end
      if (int_acc && req.space == DMMS_SP_DATA) begin
        dm_rd_ff <= dm_ram[req.addr[DMA_W-1:0]];
      end
    end
  end

  assign busy          = (state_ff != DMMS_IDLE);
  assign STALL_O       = busy || (ext_start && state_ff == DMMS_IDLE);
  assign REG_RDATA_O   = rdata_ff;
  assign IFETCH_DATA_O = ifetch_ff;
  assign PM_RDATA_O    = pm_rd_ff;
  assign DM_RDATA_O    = dm_rd_ff;
  assign INT_ACCESS_O  = int_acc;
  assign MMR_ACCESS_O  = mmr_acc;
  assign BAD_ACCESS_O  = bad_acc;
  assign FETCH_START_O = BOOT_START_ADDR;
  assign CORE_RUN_O    = run_ff;
  assign EXT_ADDR_O    = ext_addr_ff;
  assign EXT_RD_O      = busy && !ext_wr_ff && (sel_ff != '0);
  assign EXT_WR_O      = busy && ext_wr_ff && (sel_ff != '0);
  assign PMS_N_O       = ~sel_ff.prog;
  assign DMS_N_O       = ~sel_ff.data;
  assign BMS_N_O       = ~sel_ff.byte_sel;
  assign IO_SPACE_SELECT_N_O      = ~sel_ff.io;
  assign CMS_N_O       = ~composite_select;
  assign BUS_GRANT_O   = bus_req && !busy;
  assign CYCLE_CLOCK_O = cyc_clk_ff && !clk_dis_ff;
  assign MODE_STATUS_O = mode_status_reg_ff;
  assign IRQ_MASK_O    = imask_ff;
  assign STACK_PTR_O   = stack_ptr_ff;

endmodule : dmms_map

`default_nettype wire

// ===== testbench/dmms_map_asserts.sv
// Checker: port assertions for the memory map and select block
`timescale 1ns/1ps
`default_nettype none
module dmms_map_asserts
  import dmms_pkg::*;
#(
  parameter int unsigned STACK_W = 4
) (
  input wire logic               MCLK_I,
  input wire logic               RST_I,
  input wire dmms_req_t          DATA_REQ_I,
  input wire logic               STALL_O,
  input wire logic               INT_ACCESS_O,
  input wire logic [13:0]        FETCH_START_O,
  input wire logic [13:0]        EXT_ADDR_O,
  input wire logic               PMS_N_O,
  input wire logic               DMS_N_O,
  input wire logic               BMS_N_O,
  input wire logic               IO_SPACE_SELECT_N_O,
  input wire logic               CMS_N_O,
  input wire logic               BUS_GRANT_O,
  input wire logic               CYCLE_CLOCK_O,
  input wire logic [15:0]        MODE_STATUS_O,
  input wire logic [15:0]        IRQ_MASK_O,
  input wire logic [STACK_W-1:0] STACK_PTR_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  wire logic [3:0] sel = ~{PMS_N_O, DMS_N_O, BMS_N_O, IO_SPACE_SELECT_N_O};
  // A data select opens, then must close within the longest wait
  sequence ds_open;
    $fell(DMS_N_O);
  endsequence
  sequence ds_close;
    ##[1:8] DMS_N_O;
  endsequence
  one_select_a: assert property ($onehot0(sel))
    else $error("more than one select active");
  cms_source_a: assert property (!CMS_N_O |-> sel != 4'h0)
    else $error("composite select without a select");
  ds_width_a: assert property (ds_open |-> ds_close)
    else $error("data select held too long");
  sel_stall_a: assert property (sel != 4'h0 |-> STALL_O)
    else $error("select active without stall");
  int_fast_a: assert property (DATA_REQ_I.valid && INT_ACCESS_O |-> !STALL_O)
    else $error("internal access stalled");
  dm_addr_a: assert property (!DMS_N_O |-> EXT_ADDR_O[12:0] == DATA_REQ_I.addr[12:0])
    else $error("data overlay low address wrong");
  io_addr_a: assert property (!IO_SPACE_SELECT_N_O |-> EXT_ADDR_O[10:0] == DATA_REQ_I.addr[10:0])
    else $error("io address wrong");
  grant_idle_a: assert property (BUS_GRANT_O |=> sel == 4'h0 && CMS_N_O)
    else $error("select active during bus grant");
  rst_state_a: assert property ($past(RST_I) |-> MODE_STATUS_O == 16'h0000
    && IRQ_MASK_O == 16'h0000 && STACK_PTR_O == '0 && CMS_N_O)
    else $error("state after reset wrong");
  fetch_zero_a: assert property (FETCH_START_O == 14'h0000)
    else $error("first fetch address wrong");
  clk_half_a: assert property ($fell(CYCLE_CLOCK_O) |=> !CYCLE_CLOCK_O)
    else $error("cycle clock faster than half rate");
endmodule : dmms_map_asserts

bind dmms_map dmms_map_asserts #(.STACK_W(STACK_W)) dmms_map_asserts_i (
  .MCLK_I, .RST_I, .DATA_REQ_I, .STALL_O, .INT_ACCESS_O, .FETCH_START_O, .EXT_ADDR_O,
  .PMS_N_O, .DMS_N_O, .BMS_N_O, .IO_SPACE_SELECT_N_O, .CMS_N_O, .BUS_GRANT_O, .CYCLE_CLOCK_O,
  .MODE_STATUS_O, .IRQ_MASK_O, .STACK_PTR_O);
`default_nettype wire

// ===== testbench/dmms_ext_model.sv
// Model of the external overlay memories and I/O peripherals on the select pins
`timescale 1ns/1ps
`default_nettype none
module dmms_ext_model (
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic [3:0]  sel_n_i,
  input  wire logic        cms_n_i,
  input  wire logic [13:0] addr_i,
  output logic      [7:0]  sel_cnt_o,
  output logic      [7:0]  cms_cnt_o,
  output logic      [3:0]  seen_o,
  output logic      [13:0] addr_o
);
  // Each clock with a select low is one access cycle seen by the memories
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      sel_cnt_o <= 8'h00;
      cms_cnt_o <= 8'h00;
      seen_o    <= 4'h0;
      addr_o    <= 14'h0000;
    end else begin
      seen_o <= seen_o | ~sel_n_i;
      if (sel_n_i != 4'hF) begin
        sel_cnt_o <= sel_cnt_o + 8'h01;
        addr_o    <= addr_i;
      end
      if (!cms_n_i) cms_cnt_o <= cms_cnt_o + 8'h01;
    end
  end
endmodule : dmms_ext_model
`default_nettype wire

// ===== testbench/dmms_map_tb_top.sv
// Testbench: register, overlay, I/O, decode and bus request tests
`timescale 1ns/1ps
`default_nettype none
module dmms_map_tb_top;
  import dmms_pkg::*;
  logic        MCLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        BOOT_EN_I = 1'b0;
  logic        MODE_B_I = 1'b0;
  logic        prev = 1'b0;
  logic        BUS_REQ_I = 1'b0;
  logic [7:0]  REG_ADDR_I = 8'h00;
  logic [15:0] REG_WDATA_I = 16'h0000;
  logic        REG_WR_I = 1'b0;
  logic        REG_RD_I = 1'b0;
  dmms_req_t   DATA_REQ_I = '0;
  logic [23:0] PM_WDATA_I = 24'h000000;
  logic        clr = 1'b0;
  wire logic [15:0] REG_RDATA_O, MODE_STATUS_O, IRQ_MASK_O;
  wire logic [13:0] EXT_ADDR_O, ext_addr;
  wire logic [7:0]  sel_cnt, cms_cnt;
  wire logic [3:0]  seen;
  wire logic STALL_O, INT_ACCESS_O, MMR_ACCESS_O, BAD_ACCESS_O, CORE_RUN_O, PMS_N_O;
  wire logic DMS_N_O, BMS_N_O, IO_SPACE_SELECT_N_O, CMS_N_O, BUS_GRANT_O, CYCLE_CLOCK_O;
  int n_errors = 0;
  int tests_run = 0;
  int i, n;
  int wt[4] = '{0, 2, 5, 7};
  int iw[4] = '{0, 3, 5, 7};
  logic [7:0]  ra[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h20};
  logic [15:0] rv[9] = '{16'h0, 16'h0, 16'h7, 16'hFFF, 16'hB, 16'h0, 16'h0, 16'h0, 16'h0};

  always #2.5 MCLK_I = ~MCLK_I;

  dmms_map dmms_map_i (.MCLK_I, .RST_I, .MODE_B_I, .BOOT_EN_I, .BUS_REQ_I,
    .BOOT_DONE_I(1'b0), .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
    .DATA_REQ_I, .IFETCH_I(1'b0), .IFETCH_ADDR_I(14'h0000), .PM_WDATA_I, .IFETCH_DATA_O(),
    .PM_RDATA_O(), .DM_RDATA_O(), .STALL_O, .INT_ACCESS_O, .MMR_ACCESS_O, .BAD_ACCESS_O,
    .FETCH_START_O(), .CORE_RUN_O, .EXT_ADDR_O, .EXT_RD_O(), .EXT_WR_O(), .PMS_N_O,
    .DMS_N_O, .BMS_N_O, .IO_SPACE_SELECT_N_O, .CMS_N_O, .BUS_GRANT_O, .CYCLE_CLOCK_O,
    .MODE_STATUS_O, .IRQ_MASK_O, .STACK_PTR_O());
  dmms_ext_model dmms_ext_model_i (.clk_i(MCLK_I), .clr_i(clr),
    .sel_n_i({PMS_N_O, DMS_N_O, BMS_N_O, IO_SPACE_SELECT_N_O}), .cms_n_i(CMS_N_O), .addr_i(EXT_ADDR_O),
    .sel_cnt_o(sel_cnt), .cms_cnt_o(cms_cnt), .seen_o(seen), .addr_o(ext_addr));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge MCLK_I);
    REG_WR_I <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge MCLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge MCLK_I);
    REG_RD_I <= 1'b0;
    @(negedge MCLK_I);
    chk(REG_RDATA_O, e);
  endtask : rd

  // Holds the request for one cycle more than the expected select width; w of -1 means no select
  task automatic acc(input dmms_space_t sp, input logic [13:0] a, input int w,
                     input logic [3:0] s, input int c, input logic [13:0] ea);
    @(posedge MCLK_I);
    clr <= 1'b1;
    @(posedge MCLK_I);
    clr <= 1'b0;
    DATA_REQ_I <= '{1'b1, 1'b0, sp, a};
    repeat (w + 2) @(posedge MCLK_I);
    DATA_REQ_I.valid <= 1'b0;
    repeat (3) @(posedge MCLK_I);
    #1;
    chk(sel_cnt, w + 1);
    chk(seen, s);
    chk(cms_cnt, c);
    chk(sp == DMMS_SP_IO ? {3'h0, ext_addr[10:0]} : ext_addr, ea);
  endtask : acc

  task automatic dec(input logic [13:0] a, input logic [3:0] e);
    @(posedge MCLK_I);
    DATA_REQ_I <= '{1'b1, 1'b0, DMMS_SP_DATA, a};
    @(negedge MCLK_I);
    chk({INT_ACCESS_O, MMR_ACCESS_O, BAD_ACCESS_O, STALL_O}, e);
    @(posedge MCLK_I);
    DATA_REQ_I.valid <= 1'b0;
  endtask : dec

  task automatic done(input string t);
    $display("test %s done, %0d checks", t, tests_run);
  endtask : done

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    #60000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge MCLK_I);
    RST_I <= 1'b0;
    @(negedge MCLK_I);
    chk({MODE_STATUS_O, IRQ_MASK_O}, 32'h0);
    for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
    wr(8'h20, 16'h1234);
    rd(8'h20, 16'h0000);
    for (i = 0; i < 200 && CORE_RUN_O !== 1'b1; i++) @(posedge MCLK_I);
    chk(CORE_RUN_O, 1'b1);
    done("reset");
    // Overlay 1 and 2 in turn, waits at both ends, data composite enable off once
    for (i = 0; i < 4; i++) begin
      wr(8'h01, i % 2 + 1);
      wr(8'h02, wt[i]);
      wr(8'h04, (i == 1) ? 16'h9 : 16'hB);
      n = (i == 1) ? 0 : wt[i] + 1;
      acc(DMMS_SP_DATA, 14'h1ABC, wt[i], 4'h4, n, {i[0], 13'h1ABC});
    end
    done("data overlay");
    wr(8'h02, 16'h0);
    for (i = 1; i < 3; i++) begin
      wr(8'h00, i);
      acc(DMMS_SP_PROG, 14'h2456, 0, 4'h8, 1, {i[1], 13'h0456});
    end
    wr(8'h00, 16'h0);
    acc(DMMS_SP_PROG, 14'h0100, -1, 4'h0, 0, 14'h0000);
    done("program overlay");
    wr(8'h03, 16'hF58);
    rd(8'h03, 16'hF58);
    for (i = 0; i < 4; i++) begin
      acc(DMMS_SP_IO, {3'h0, i[1:0], 9'h1F5}, iw[i], 4'h1, iw[i] + 1,
          {3'h0, i[1:0], 9'h1F5});
    end
    done("io waits");
    wr(8'h01, 16'h0);
    dec(14'h2005, 4'b1000);
    dec(14'h3FE5, 4'b0100);
    dec(14'h3100, 4'b0010);
    dec(14'h0100, 4'b0010);
    done("decode");
    wr(8'h01, 16'h1);
    @(posedge MCLK_I);
    BUS_REQ_I <= 1'b1;
    repeat (4) @(posedge MCLK_I);
    @(negedge MCLK_I);
    chk(BUS_GRANT_O, 1'b1);
    acc(DMMS_SP_DATA, 14'h0040, -1, 4'h0, 0, 14'h0000);
    @(posedge MCLK_I);
    BUS_REQ_I <= 1'b0;
    done("bus request");
    MODE_B_I <= 1'b1;
    repeat (4) @(posedge MCLK_I);
    acc(DMMS_SP_PROG, 14'h0100, 0, 4'h8, 1, 14'h0100);
    MODE_B_I <= 1'b0;
    repeat (4) @(posedge MCLK_I);
    done("mode b");
    wr(8'h05, 16'h1);
    repeat (4) @(posedge MCLK_I);
    for (i = 0; i < 6; i++) begin
      @(negedge MCLK_I);
      chk(CYCLE_CLOCK_O, 1'b0);
    end
    wr(8'h05, 16'h0);
    repeat (4) @(posedge MCLK_I);
    n = 0;
    @(negedge MCLK_I);
    for (i = 0; i < 8; i++) begin
      prev = CYCLE_CLOCK_O;
      @(negedge MCLK_I);
      if (CYCLE_CLOCK_O !== prev) n++;
    end
    chk(n, 4);
    done("cycle clock");
    give_verdict();
  end
endmodule : dmms_map_tb_top
`default_nettype wire
